// >>> rtl/stbm_regs.vh
`ifndef STBM_REGS_VH
`define STBM_REGS_VH
// ************************************************************
// tag store geometry and operation codes
// ************************************************************
`define STBM_INDEX_W   6
`define STBM_TAG_W     14
`define STBM_WAY_W     2
`define STBM_DATA_W    32
`define STBM_OP_NONE   3'h0
`define STBM_OP_LOOKUP 3'h1
`define STBM_OP_REPL   3'h2
`define STBM_OP_PURGE  3'h3
`define STBM_OP_INVAL  3'h4
`define STBM_OP_READ   3'h5
`define STBM_POL_INVAL 1'b0
`define STBM_POL_UPDT  1'b1
`endif

// >>> rtl/stbm_tag_store.v
`timescale 1ns/1ps
`include "stbm_regs.vh"
// ************************************************************
// four way tag store with residency compare and lru order
// ************************************************************
module stbm_tag_store #(
	parameter IW = `STBM_INDEX_W,
	parameter TW = `STBM_TAG_W,
	parameter USE_LRU = 1
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          ce,
	input  wire [2:0]    op,
	input  wire [IW-1:0] index,
	input  wire [TW-1:0] tag,
	input  wire          upd_strobe,
	input  wire          way_select_enable,
	input  wire [1:0]    way_select_in,
	output wire          hit,
	output wire [1:0]    hit_way_code,
	output wire [1:0]    victim_way
);
	localparam DEPTH = 1 << IW;
	reg [TW-1:0] tag_mem [0:4*DEPTH-1];
	reg [3:0]    vld_q   [0:DEPTH-1];
	reg [1:0]    lru_q   [0:DEPTH-1];
	wire [3:0]   match;
	integer      i;
	genvar       g;
	// parallel compare of all ways
	generate
		for (g = 0; g < 4; g = g + 1) begin : cmp
			assign match[g] = vld_q[index][g] && (tag_mem[{index, g[1:0]}] == tag);
		end
	endgenerate
	assign hit = |match;
	assign hit_way_code = match[3] ? 2'h3 : match[2] ? 2'h2 : match[1] ? 2'h1 : 2'h0;
	assign victim_way = USE_LRU ? lru_q[index] : 2'h0;
	// selected way: external select, own hit way to clear, else own replacement choice
	wire [1:0] wsel = way_select_enable ? way_select_in :
		(op == `STBM_OP_INVAL) ? hit_way_code : lru_q[index];
	// tag, valid and replacement order update
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				vld_q[i] <= 4'h0;
				lru_q[i] <= 2'h0;
			end
		end else if (ce) begin
			if (op == `STBM_OP_REPL) begin
				tag_mem[{index, wsel}] <= tag;
				vld_q[index][wsel] <= 1'b1;
			end else if (op == `STBM_OP_PURGE) begin
				vld_q[index] <= 4'h0;
			end else if (op == `STBM_OP_INVAL) begin
				vld_q[index][wsel] <= 1'b0;
			end
			if (USE_LRU != 0 && upd_strobe && op == `STBM_OP_LOOKUP)
				lru_q[index] <= hit ? hit_way_code + 2'h1 : lru_q[index] + 2'h1;
		end
	end
endmodule

// >>> rtl/stbm_monitor.v
`timescale 1ns/1ps
`include "stbm_regs.vh"
module stbm_monitor #(
	parameter IW     = `STBM_INDEX_W,
	parameter TW     = `STBM_TAG_W,
	parameter DW     = `STBM_DATA_W,
	parameter POLICY = `STBM_POL_INVAL
) (
	input  wire          clk,
	input  wire          resetn,
	input  wire          ce,
	input  wire          single_store,
	input  wire [2:0]    cpu_op,
	input  wire [IW-1:0] cpu_index,
	input  wire [TW-1:0] cpu_tag,
	input  wire          sys_wr,
	input  wire [IW-1:0] sys_index,
	input  wire [TW-1:0] sys_tag,
	input  wire [DW-1:0] sys_data,
	output reg           cpu_hit,
	output reg  [1:0]    cpu_way,
	output reg           cpu_stall,
	output reg           snoop_hit,
	output reg           snoop_inval,
	output reg           data_we,
	output reg  [IW-1:0] data_index,
	output reg  [1:0]    data_way,
	output reg  [DW-1:0] data_wdata
);
	// ************************************************************
	// reset release
	// ************************************************************
	reg  rs1_q, rs2_q;
	wire rst_n = rs2_q;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end

	// ************************************************************
	// snoop state machine
	// ************************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_ACT  = 2'h1;
	reg [1:0]    st_q;
	reg [IW-1:0] s_idx_q;
	reg [TW-1:0] s_tag_q;
	reg [1:0]    s_way_q;
	reg [DW-1:0] s_data_q;

	// decode of ops that change tags or validity
	function is_modify;
		input [2:0] op;
		begin
			is_modify = (op == `STBM_OP_REPL) || (op == `STBM_OP_PURGE) ||
				(op == `STBM_OP_INVAL);
		end
	endfunction

	// processor op preempted by snoop in single store mode
	wire addr_clash = (sys_index == cpu_index) && (sys_tag == cpu_tag);
	wire snoop_go   = sys_wr && st_q == ST_IDLE;
	wire snoop_act  = st_q == ST_ACT;
	wire inval_act  = snoop_act && POLICY == `STBM_POL_INVAL;
	wire clash_hold = single_store && snoop_go && addr_clash;
	// a modify op cannot be mirrored while the shadow serves a snoop, so it waits
	wire path_hold  = (snoop_go && is_modify(cpu_op)) ||
		(inval_act && cpu_op != `STBM_OP_NONE);
	wire cpu_hold   = clash_hold || path_hold;

	// ************************************************************
	// primary buffer controls
	// ************************************************************
	reg  [2:0]    p_op;
	reg  [IW-1:0] p_idx;
	reg  [TW-1:0] p_tag;
	reg           p_strobe;
	wire          p_hit;
	wire [1:0]    p_hcode;
	wire [1:0]    p_victim;
	wire          sh_hit;
	wire [1:0]    sh_hcode;
	wire          sh_en;
	reg  [2:0]    sh_op;
	reg  [IW-1:0] sh_idx;
	reg  [TW-1:0] sh_tag;
	wire [2:0]    cpu_eff = cpu_hold ? `STBM_OP_NONE : cpu_op;

	// shadow enable low only while it serves a snoop inquiry
	assign sh_en = !snoop_go;
	// snoop invalidation on primary uses captured index and tag with its own hit way
	always @* begin
		p_op     = cpu_eff;
		p_idx    = cpu_index;
		p_tag    = cpu_tag;
		p_strobe = cpu_eff == `STBM_OP_LOOKUP;
		if (inval_act) begin
			p_op     = `STBM_OP_INVAL;
			p_idx    = s_idx_q;
			p_tag    = s_tag_q;
			p_strobe = 1'b0;
		end
	end

	// shadow follows modifications; snoop inquiry never updates order
	always @* begin
		sh_op  = `STBM_OP_NONE;
		sh_idx = p_idx;
		sh_tag = p_tag;
		if (snoop_go) begin
			sh_op  = `STBM_OP_LOOKUP;
			sh_idx = sys_index;
			sh_tag = sys_tag;
		end else if (is_modify(p_op)) begin
			sh_op = p_op;
		end
	end

	// primary way select: shadow hit code during a snoop, own choice otherwise
	wire [1:0] p_sel = sh_hcode;
	wire       p_en  = !sh_en;

	stbm_tag_store #(.IW(IW), .TW(TW), .USE_LRU(1)) u_primary (
		.clk               (clk),
		.rst_n             (rst_n),
		.ce                (ce),
		.op                (p_op),
		.index             (p_idx),
		.tag               (p_tag),
		.upd_strobe        (p_strobe),
		.way_select_enable (p_en),
		.way_select_in     (p_sel),
		.hit               (p_hit),
		.hit_way_code      (p_hcode),
		.victim_way        (p_victim)
	);

	// ************************************************************
	// shadow buffer, residency only
	// ************************************************************
	wire [1:0] sh_sel;

	// way that the primary really writes or clears
	function [1:0] mirror_way;
		input [2:0] op;
		input [1:0] victim;
		input [1:0] hcode;
		begin
			mirror_way = (op == `STBM_OP_REPL) ? victim : hcode;
		end
	endfunction
	assign sh_sel = mirror_way(p_op, p_victim, p_hcode);

	stbm_tag_store #(.IW(IW), .TW(TW), .USE_LRU(0)) u_shadow (
		.clk               (clk),
		.rst_n             (rst_n),
		.ce                (ce),
		.op                (inval_act ? `STBM_OP_INVAL : sh_op),
		.index             (inval_act ? s_idx_q : sh_idx),
		.tag               (sh_tag),
		.upd_strobe        (1'b0),
		.way_select_enable (sh_en),
		.way_select_in     (inval_act ? s_way_q : sh_sel),
		.hit               (sh_hit),
		.hit_way_code      (sh_hcode),
		.victim_way        ()
	);

	// ************************************************************
	// snoop sequencing and outputs
	// ************************************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q        <= ST_IDLE;
			s_idx_q     <= {IW{1'b0}};
			s_tag_q     <= {TW{1'b0}};
			s_way_q     <= 2'h0;
			s_data_q    <= {DW{1'b0}};
			cpu_hit     <= 1'b0;
			cpu_way     <= 2'h0;
			cpu_stall   <= 1'b0;
			snoop_hit   <= 1'b0;
			snoop_inval <= 1'b0;
			data_we     <= 1'b0;
			data_index  <= {IW{1'b0}};
			data_way    <= 2'h0;
			data_wdata  <= {DW{1'b0}};
		end else if (ce) begin
			cpu_hit     <= p_hit && cpu_eff == `STBM_OP_LOOKUP;
			cpu_way     <= p_hcode;
			snoop_hit   <= snoop_go && sh_hit;
			snoop_inval <= inval_act;
			data_we     <= snoop_act && POLICY == `STBM_POL_UPDT;
			data_index  <= s_idx_q;
			data_way    <= s_way_q;
			data_wdata  <= s_data_q;
			cpu_stall   <= cpu_hold || (snoop_go && sh_hit && POLICY == `STBM_POL_UPDT);
			case (st_q)
				ST_IDLE: begin
					if (snoop_go && sh_hit) begin
						st_q     <= ST_ACT;
						s_idx_q  <= sys_index;
						s_tag_q  <= sys_tag;
						s_way_q  <= sh_hcode;
						s_data_q <= sys_data;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> bench/stbm_chk_monitor.sv
`timescale 1ns/1ps
`include "stbm_regs.vh"
// ************************************************************
// port checker for the snoop path
// ************************************************************
module stbm_chk #(
	parameter POLICY = `STBM_POL_INVAL
) (
	input wire        clk,
	input wire        resetn,
	input wire        sys_wr,
	input wire [5:0]  sys_index,
	input wire [31:0] sys_data,
	input wire        snoop_hit,
	input wire        snoop_inval,
	input wire        data_we,
	input wire [5:0]  data_index,
	input wire [31:0] data_wdata,
	input wire        cpu_stall
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// a hit is followed next cycle by exactly one action
	sequence s_inval_step; ##1 (snoop_inval && !data_we); endsequence
	sequence s_updt_step; ##1 (data_we && !snoop_inval); endsequence
	a_hit_from_write: assert property (snoop_hit |-> $past(sys_wr))
		else $error("snoop hit without bus write");
	a_inval_follows: assert property ((POLICY == 0) && snoop_hit |-> s_inval_step)
		else $error("invalidate missing after hit");
	a_updt_follows: assert property ((POLICY == 1) && snoop_hit |-> s_updt_step)
		else $error("data write missing after hit");
	a_action_cause: assert property (snoop_inval || data_we |-> $past(snoop_hit))
		else $error("action without snoop hit");
	a_updt_payload: assert property (data_we |->
		data_index == $past(sys_index, 2) && data_wdata == $past(sys_data, 2))
		else $error("data write payload wrong");
	a_hit_refused: assert property (snoop_hit |=> !snoop_hit)
		else $error("write after hit not ignored");
	a_updt_stall: assert property ((POLICY == 1) && snoop_hit |-> cpu_stall)
		else $error("no stall on update hit");
	a_inval_only: assert property ((POLICY == 0) |-> !data_we)
		else $error("data write under invalidate policy");
	a_updt_only: assert property ((POLICY == 1) |-> !snoop_inval)
		else $error("invalidate under update policy");
endmodule

// >>> bench/stbm_bus_master.sv
`timescale 1ns/1ps
// ************************************************************
// system bus master issuing snooped writes
// ************************************************************
module stbm_bus_master (
	input  wire        clk,
	input  wire        req,
	input  wire [5:0]  idx,
	input  wire [13:0] tag,
	input  wire [31:0] dat,
	output wire        sys_wr,
	output wire [5:0]  sys_index,
	output wire [13:0] sys_tag,
	output wire [31:0] sys_data
);
	reg [51:0] last_q = 52'h0;
	// released bus shows the inverse of the last driven cycle
	always @(posedge clk) begin
		if (req)
			last_q <= {idx, tag, dat};
	end
	assign sys_wr = req;
	assign {sys_index, sys_tag, sys_data} = req ? {idx, tag, dat} : ~last_q;
endmodule

// >>> bench/stbm_monitor_test.sv
`timescale 1ns/1ps
`include "stbm_regs.vh"
module stbm_monitor_test;
	localparam D = 32'h5AC39E17;
	reg         clk = 1'h0;
	reg         resetn = 1'h0;
	reg         single_store = 1'h0;
	reg  [2:0]  cpu_op = 3'h0;
	reg  [5:0]  idx = 6'h00;
	reg  [13:0] tag = 14'h0000;
	reg         req = 1'h0;
	wire        sys_wr, hit, s_hit, s_inv, stall, u_hit, u_we, u_stall;
	wire [5:0]  sys_index, u_idx;
	wire [1:0]  way, u_way;
	wire [13:0] sys_tag;
	wire [31:0] sys_data, u_dat;
	integer     err_total = 0;
	integer     num_checks = 0;
	integer     i;
	reg  [26:0] rows [0:11];
	// ************************************************************
	// clock, partner and both policy variants
	// ************************************************************
	always #12.5 clk = ~clk;
	stbm_bus_master bm (.clk(clk), .req(req), .idx(idx), .tag(tag), .dat(D),
		.sys_wr(sys_wr), .sys_index(sys_index), .sys_tag(sys_tag), .sys_data(sys_data));
	stbm_monitor #(.POLICY(`STBM_POL_INVAL)) dut (.clk(clk), .resetn(resetn), .ce(1'h1),
		.single_store(single_store), .cpu_op(cpu_op), .cpu_index(idx), .cpu_tag(tag),
		.sys_wr(sys_wr), .sys_index(sys_index), .sys_tag(sys_tag), .sys_data(sys_data),
		.cpu_hit(hit), .cpu_way(way), .cpu_stall(stall), .snoop_hit(s_hit), .snoop_inval(s_inv),
		.data_we(), .data_index(), .data_way(), .data_wdata());
	stbm_monitor #(.POLICY(`STBM_POL_UPDT)) dut_upd (.clk(clk), .resetn(resetn), .ce(1'h1),
		.single_store(single_store), .cpu_op(cpu_op), .cpu_index(idx), .cpu_tag(tag),
		.sys_wr(sys_wr), .sys_index(sys_index), .sys_tag(sys_tag), .sys_data(sys_data),
		.cpu_hit(), .cpu_way(), .cpu_stall(u_stall), .snoop_hit(u_hit), .snoop_inval(),
		.data_we(u_we), .data_index(u_idx), .data_way(u_way), .data_wdata(u_dat));
	// compare and count
	task check(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// verdict and end of run
	task test_done;
		begin
			if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	// one request cycle, then idle; returns after the answer edge
	task apply(input [2:0] op, input r, input [5:0] ix, input [13:0] tg);
		begin
			@(posedge clk) begin
				cpu_op <= op; req <= r; idx <= ix; tag <= tg;
			end
			@(posedge clk) begin
				cpu_op <= `STBM_OP_NONE; req <= 1'h0;
			end
			#1;
		end
	endtask
	// watchdog
	initial begin
		#20000;
		err_total = err_total + 1;
		test_done;
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		// rows: op, write, index, tag, lookup hit, snoop hit, update hit
		rows[0] = {3'h2, 1'h0, 6'h05, 14'h0123, 3'h0};
		rows[1] = {3'h1, 1'h0, 6'h05, 14'h0123, 3'h4};
		rows[2] = {3'h0, 1'h1, 6'h05, 14'h0123, 3'h3};
		rows[3] = {3'h1, 1'h0, 6'h05, 14'h0123, 3'h0};
		rows[4] = {3'h0, 1'h1, 6'h05, 14'h0123, 3'h1};
		rows[5] = {3'h2, 1'h0, 6'h05, 14'h02AA, 3'h0};
		rows[6] = {3'h3, 1'h0, 6'h05, 14'h0000, 3'h0};
		rows[7] = {3'h0, 1'h1, 6'h05, 14'h02AA, 3'h0};
		rows[8] = {3'h2, 1'h0, 6'h09, 14'h03C1, 3'h0};
		rows[9] = {3'h5, 1'h0, 6'h09, 14'h03C1, 3'h0};
		rows[10] = {3'h4, 1'h0, 6'h09, 14'h03C1, 3'h0};
		rows[11] = {3'h0, 1'h1, 6'h09, 14'h03C1, 3'h0};
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 12; i = i + 1) begin
			apply(rows[i][26:24], rows[i][23], rows[i][22:17], rows[i][16:3]);
			if (rows[i][26:24] == `STBM_OP_LOOKUP) check(hit, rows[i][2]);
			check(s_hit, rows[i][1]);
			check(u_stall, rows[i][0]);
			@(posedge clk) #1;
			check(s_inv, rows[i][1]);
			check(u_we, rows[i][0]);
			if (rows[i][0]) check(u_dat, D);
			if (rows[i][0]) check(u_idx, rows[i][22:17]);
		end
		// back to back bus writes: the second is ignored
		apply(`STBM_OP_REPL, 1'h0, 6'h09, 14'h03C1);
		@(posedge clk) req <= 1'h1;
		@(posedge clk);
		#1 check(u_hit, 1'h1);
		@(posedge clk) req <= 1'h0;
		#1 check(u_hit, 1'h0);
		// way steering: second replacement lands in the next way and is snooped there
		apply(`STBM_OP_REPL, 1'h0, 6'h21, 14'h0A5A);
		apply(`STBM_OP_LOOKUP, 1'h0, 6'h21, 14'h0A5A);
		check(way, 2'h0);
		apply(`STBM_OP_REPL, 1'h0, 6'h21, 14'h15A5);
		apply(`STBM_OP_LOOKUP, 1'h0, 6'h21, 14'h15A5);
		check({hit, way}, 3'h5);
		apply(`STBM_OP_NONE, 1'h1, 6'h21, 14'h15A5);
		check({s_hit, u_hit}, 2'h3);
		@(posedge clk) #1;
		check({s_inv, u_we, u_way}, 4'hD);
		// replacement in a snoop cycle is held so both buffers stay alike
		apply(`STBM_OP_REPL, 1'h1, 6'h30, 14'h0111);
		check({stall, u_stall}, 2'h3);
		// single store mode: address clash stalls the processor
		single_store <= 1'h1;
		apply(`STBM_OP_LOOKUP, 1'h1, 6'h09, 14'h03C1);
		check(stall, 1'h1);
		// reset in mid run clears the outputs
		@(posedge clk) resetn <= 1'h0;
		#1 check({s_hit, stall, u_we, u_stall}, 4'h0);
		single_store <= 1'h0;
		// release again: both buffers come back empty
		@(posedge clk) resetn <= 1'h1;
		repeat (3) @(posedge clk);
		apply(`STBM_OP_LOOKUP, 1'h1, 6'h21, 14'h15A5);
		check({hit, s_hit, u_hit, stall}, 4'h0);
		test_done;
	end
endmodule
bind stbm_monitor stbm_chk #(.POLICY(POLICY)) u_chk (.clk(clk), .resetn(resetn),
	.sys_wr(sys_wr), .sys_index(sys_index), .sys_data(sys_data), .snoop_hit(snoop_hit),
	.snoop_inval(snoop_inval), .data_we(data_we), .data_index(data_index),
	.data_wdata(data_wdata), .cpu_stall(cpu_stall));
